// ---- shared/irq_flag_pkg.sv ----
package irq_flag_pkg;

  localparam int          WORD_W    = 16;
  localparam int          REG_COUNT = 4;
  localparam int          ADDR_W    = 4;

  // Register word addresses on the plain register port.
  localparam logic [3:0]  ADDR_IRQ_FLAGS_0 = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_FLAGS_1 = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_FLAGS_2 = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_FLAGS_3 = 4'h3;
  localparam logic [REG_COUNT-1:0][3:0] REG_ADDRS =
    {ADDR_IRQ_FLAGS_3, ADDR_IRQ_FLAGS_2, ADDR_IRQ_FLAGS_1, ADDR_IRQ_FLAGS_0};

  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] RDATA_IDLE  = 16'h0000;

  // Implemented bit masks, one per flag word.
  localparam logic [15:0] IMPL_MASK_0 = 16'h3fef;
  localparam logic [15:0] IMPL_MASK_1 = 16'hfe1f;
  localparam logic [15:0] IMPL_MASK_2 = 16'h22e3;
  localparam logic [15:0] IMPL_MASK_3 = 16'h4006;
  localparam logic [REG_COUNT-1:0][15:0] IMPL_MASKS =
    {IMPL_MASK_3, IMPL_MASK_2, IMPL_MASK_1, IMPL_MASK_0};

  // Word 0 field positions.
  localparam int POS_ADC_DONE_FLAG   = 13;
  localparam int POS_UART_A_TX_FLAG  = 12;
  localparam int POS_UART_A_RX_FLAG  = 11;
  localparam int POS_SPI_A_EVENT     = 10;
  localparam int POS_SPI_A_FAULT     = 9;
  localparam int POS_TIMER_C_FLAG    = 8;
  localparam int POS_TIMER_B_FLAG    = 7;
  localparam int POS_COMPARE_B_FLAG  = 6;
  localparam int POS_CAPTURE_B_FLAG  = 5;
  localparam int POS_TIMER_A_FLAG    = 3;
  localparam int POS_COMPARE_A_FLAG  = 2;
  localparam int POS_CAPTURE_A_FLAG  = 1;
  localparam int POS_EXT_IRQ_A_FLAG  = 0;
  // Word 1 field positions.
  localparam int POS_UART_B_TX_FLAG  = 15;
  localparam int POS_UART_B_RX_FLAG  = 14;
  localparam int POS_EXT_IRQ_C_FLAG  = 13;
  localparam int POS_TIMER_E_FLAG    = 12;
  localparam int POS_TIMER_D_FLAG    = 11;
  localparam int POS_COMPARE_D_FLAG  = 10;
  localparam int POS_COMPARE_C_FLAG  = 9;
  localparam int POS_EXT_IRQ_B_FLAG  = 4;
  localparam int POS_PIN_CHANGE_FLAG = 3;
  localparam int POS_COMPARATOR_FLAG = 2;
  localparam int POS_I2C_A_MASTER    = 1;
  localparam int POS_I2C_A_SLAVE     = 0;
  // Word 2 field positions.
  localparam int POS_PARALLEL_PORT   = 13;
  localparam int POS_COMPARE_E_FLAG  = 9;
  localparam int POS_CAPTURE_E_FLAG  = 7;
  localparam int POS_CAPTURE_D_FLAG  = 6;
  localparam int POS_CAPTURE_C_FLAG  = 5;
  localparam int POS_SPI_B_EVENT     = 1;
  localparam int POS_SPI_B_FAULT     = 0;
  // Word 3 field positions.
  localparam int POS_CALENDAR_FLAG   = 14;
  localparam int POS_I2C_B_MASTER    = 2;
  localparam int POS_I2C_B_SLAVE     = 1;

  typedef struct packed {
    logic [15:0] flags;
  } word_state_s;

  typedef struct packed {
    logic [15:0] rdata;
  } bus_state_s;

endpackage : irq_flag_pkg

// ---- rtl/irq_flag_word.sv ----
`timescale 1ns/1ps
module irq_flag_word
  import irq_flag_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hffff
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_evt,
  output logic      [15:0] o_flags
);

  word_state_s state_reg;
  word_state_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next flag value. The event term is OR-ed in last, so a request that lands
  // on a clearing write still survives instead of being wiped by software.
  always_comb begin
    state_next = state_reg;
    if (i_wr_en) begin
      state_next.flags = i_wdata;
    end
    state_next.flags = (state_next.flags | i_evt) & IMPL_MASK; // Masked bits never hold a one.
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg.flags <= FLAGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_flags = state_reg.flags;

endmodule : irq_flag_word

// ---- rtl/irq_flag_bank.sv ----
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module irq_flag_bank
  import irq_flag_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  // Register port.
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [15:0]       o_rdata,
  // Word 0 event pulses.
  input  wire logic              i_adc_done_flag_set,
  input  wire logic              i_uart_a_tx_flag_set,
  input  wire logic              i_uart_a_rx_flag_set,
  input  wire logic              i_spi_a_event_flag_set,
  input  wire logic              i_spi_a_fault_flag_set,
  input  wire logic              i_timer_c_flag_set,
  input  wire logic              i_timer_b_flag_set,
  input  wire logic              i_compare_b_flag_set,
  input  wire logic              i_capture_b_flag_set,
  input  wire logic              i_timer_a_flag_set,
  input  wire logic              i_compare_a_flag_set,
  input  wire logic              i_capture_a_flag_set,
  input  wire logic              i_ext_irq_a_flag_set,
  // Word 1 event pulses.
  input  wire logic              i_uart_b_tx_flag_set,
  input  wire logic              i_uart_b_rx_flag_set,
  input  wire logic              i_ext_irq_c_flag_set,
  input  wire logic              i_timer_e_flag_set,
  input  wire logic              i_timer_d_flag_set,
  input  wire logic              i_compare_d_flag_set,
  input  wire logic              i_compare_c_flag_set,
  input  wire logic              i_ext_irq_b_flag_set,
  input  wire logic              i_pin_change_flag_set,
  input  wire logic              i_comparator_flag_set,
  input  wire logic              i_i2c_a_master_flag_set,
  input  wire logic              i_i2c_a_slave_flag_set,
  // Word 2 event pulses.
  input  wire logic              i_parallel_port_flag_set,
  input  wire logic              i_compare_e_flag_set,
  input  wire logic              i_capture_e_flag_set,
  input  wire logic              i_capture_d_flag_set,
  input  wire logic              i_capture_c_flag_set,
  input  wire logic              i_spi_b_event_flag_set,
  input  wire logic              i_spi_b_fault_flag_set,
  // Word 3 event pulses.
  input  wire logic              i_calendar_flag_set,
  input  wire logic              i_i2c_b_master_flag_set,
  input  wire logic              i_i2c_b_slave_flag_set,
  // Flag words toward the interrupt logic.
  output logic      [15:0]       o_irq_flags_0,
  output logic      [15:0]       o_irq_flags_1,
  output logic      [15:0]       o_irq_flags_2,
  output logic      [15:0]       o_irq_flags_3
);

  logic [REG_COUNT-1:0][15:0] evt;
  logic [REG_COUNT-1:0][15:0] flags;
  logic [REG_COUNT-1:0]       wr_en;
  logic [REG_COUNT-1:0]       sel;
  logic [15:0]                rd_mux;
  bus_state_s                 state_reg;
  bus_state_s                 state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Event routing. Sources arrive as one-cycle pulses from logic on this
  // clock, so no synchroniser sits in front of them.
  // vector order mapping
  always_comb begin
    evt = '0;
    evt[0][POS_ADC_DONE_FLAG]   = i_adc_done_flag_set;
    evt[0][POS_UART_A_TX_FLAG]  = i_uart_a_tx_flag_set;
    evt[0][POS_UART_A_RX_FLAG]  = i_uart_a_rx_flag_set;
    evt[0][POS_SPI_A_EVENT]     = i_spi_a_event_flag_set;
    evt[0][POS_SPI_A_FAULT]     = i_spi_a_fault_flag_set;
    evt[0][POS_TIMER_C_FLAG]    = i_timer_c_flag_set;
    evt[0][POS_TIMER_B_FLAG]    = i_timer_b_flag_set;
    evt[0][POS_COMPARE_B_FLAG]  = i_compare_b_flag_set;
    evt[0][POS_CAPTURE_B_FLAG]  = i_capture_b_flag_set;
    evt[0][POS_TIMER_A_FLAG]    = i_timer_a_flag_set;
    evt[0][POS_COMPARE_A_FLAG]  = i_compare_a_flag_set;
    evt[0][POS_CAPTURE_A_FLAG]  = i_capture_a_flag_set;
    evt[0][POS_EXT_IRQ_A_FLAG]  = i_ext_irq_a_flag_set;
    evt[1][POS_UART_B_TX_FLAG]  = i_uart_b_tx_flag_set;
    evt[1][POS_UART_B_RX_FLAG]  = i_uart_b_rx_flag_set;
    evt[1][POS_EXT_IRQ_C_FLAG]  = i_ext_irq_c_flag_set;
    evt[1][POS_TIMER_E_FLAG]    = i_timer_e_flag_set;
    evt[1][POS_TIMER_D_FLAG]    = i_timer_d_flag_set;
    evt[1][POS_COMPARE_D_FLAG]  = i_compare_d_flag_set;
    evt[1][POS_COMPARE_C_FLAG]  = i_compare_c_flag_set;
    evt[1][POS_EXT_IRQ_B_FLAG]  = i_ext_irq_b_flag_set;
    evt[1][POS_PIN_CHANGE_FLAG] = i_pin_change_flag_set;
    evt[1][POS_COMPARATOR_FLAG] = i_comparator_flag_set;
    evt[1][POS_I2C_A_MASTER]    = i_i2c_a_master_flag_set;
    evt[1][POS_I2C_A_SLAVE]     = i_i2c_a_slave_flag_set;
    evt[2][POS_PARALLEL_PORT]   = i_parallel_port_flag_set;
    evt[2][POS_COMPARE_E_FLAG]  = i_compare_e_flag_set;
    evt[2][POS_CAPTURE_E_FLAG]  = i_capture_e_flag_set;
    evt[2][POS_CAPTURE_D_FLAG]  = i_capture_d_flag_set;
    evt[2][POS_CAPTURE_C_FLAG]  = i_capture_c_flag_set;
    evt[2][POS_SPI_B_EVENT]     = i_spi_b_event_flag_set;
    evt[2][POS_SPI_B_FAULT]     = i_spi_b_fault_flag_set;
    evt[3][POS_CALENDAR_FLAG]   = i_calendar_flag_set;
    evt[3][POS_I2C_B_MASTER]    = i_i2c_b_master_flag_set;
    evt[3][POS_I2C_B_SLAVE]     = i_i2c_b_slave_flag_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One flag word per register; decode and storage repeat per word.
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_word
      assign sel[g]   = (i_addr == REG_ADDRS[g]);
      assign wr_en[g] = i_wr && sel[g];
      irq_flag_word #(
        .IMPL_MASK (IMPL_MASKS[g])
      ) u_word (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_wr_en   (wr_en[g]),
        .i_wdata   (i_wdata),
        .i_evt     (evt[g]),
        .o_flags   (flags[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Unmapped addresses select nothing and so return zero; the
  // read shows the flags before any same-cycle write takes effect.
  always_comb begin
    rd_mux = RDATA_IDLE;
    for (int k = 0; k < REG_COUNT; k++) begin
      if (sel[k]) begin
        rd_mux = flags[k];
      end
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_comb begin
    state_next = state_reg;
    state_next.rdata = i_rd ? rd_mux : RDATA_IDLE;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg.rdata <= RDATA_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata       = state_reg.rdata;
  assign o_irq_flags_0 = flags[0];
  assign o_irq_flags_1 = flags[1];
  assign o_irq_flags_2 = flags[2];
  assign o_irq_flags_3 = flags[3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own outputs.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  // Helper copies of the previous read address and of all flag words.
  // They bypass the read mux, so a broken mux cannot agree with itself.
  logic [ADDR_W-1:0]          prev_addr;
  logic [REG_COUNT-1:0][15:0] prev_flags;
  always_ff @(posedge i_sys_clk) begin
    prev_addr  <= i_addr;
    prev_flags <= flags;
  end

  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_chk
      reset_clears_a: assert property (disable iff (1'b0)
        $past(i_srst) |-> flags[g] == FLAGS_RESET)
        else $error("flag word not zero after reset");
      unused_zero_a: assert property (
        (flags[g] & ~IMPL_MASKS[g]) == 16'h0000)
        else $error("unimplemented flag bit reads one");
      event_sets_a: assert property (
        (evt[g] != 16'h0000) |=> ((flags[g] & $past(evt[g])) == $past(evt[g])))
        else $error("source event did not set its flag");
      set_wins_a: assert property (
        (wr_en[g] && (evt[g] != 16'h0000)) |=>
        flags[g] == (($past(i_wdata) | $past(evt[g])) & IMPL_MASKS[g]))
        else $error("write and event merged wrongly");
      sticky_hold_a: assert property (
        (!wr_en[g] && evt[g] == 16'h0000) |=> $stable(flags[g]))
        else $error("flag word changed without cause");
      // clear needs a write
      // Reset clears the word as well, and its effect shows one edge after the edge that samples reset high.
      clear_by_write_a: assert property (
        ((flags[g] & ~$past(flags[g])) == 16'h0000 && flags[g] != $past(flags[g]))
        |-> $past(wr_en[g] || i_srst))
        else $error("flag cleared without a software write");
    end
  endgenerate

  read_data_a: assert property (
    (i_rd && i_addr <= ADDR_IRQ_FLAGS_3) |=> o_rdata == prev_flags[prev_addr[1:0]])
    else $error("read data differ from addressed flags");

  read_idle_a: assert property (
    !i_rd |=> o_rdata == RDATA_IDLE)
    else $error("read data present without a read strobe");

  unmapped_read_a: assert property (
    (i_rd && i_addr > ADDR_IRQ_FLAGS_3) |=> o_rdata == 16'h0000)
    else $error("unmapped address returned nonzero data");

  adc_map_a: assert property (
    i_adc_done_flag_set |=> o_irq_flags_0[13])
    else $error("adc request not at word 0 bit 13");

  ext_a_map_a: assert property (
    i_ext_irq_a_flag_set |=> o_irq_flags_0[0])
    else $error("ext A request not at word 0 bit 0");

  uart_b_map_a: assert property (
    i_uart_b_tx_flag_set |=> o_irq_flags_1[15])
    else $error("uart B tx request not at word 1 bit 15");

  ext_b_map_a: assert property (
    i_ext_irq_b_flag_set |=> o_irq_flags_1[4])
    else $error("ext B request not at word 1 bit 4");

  parallel_map_a: assert property (
    i_parallel_port_flag_set |=> o_irq_flags_2[13])
    else $error("parallel port request not at word 2 bit 13");

  calendar_map_a: assert property (
    i_calendar_flag_set |=> o_irq_flags_3[14])
    else $error("calendar request not at word 3 bit 14");

endmodule : irq_flag_bank

// ---- tb/irq_event_source.sv ----
`timescale 1ns/1ps
// Stand-in for the peripheral event producers around the flag bank.
module irq_event_source (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic [34:0] i_req,
  output logic      [34:0] o_set
);
  // event pulse launch
  // Pulses leave a flop, so the bank sees them exactly as a same-clock peripheral would drive them.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_set <= 35'h0;
    end else begin
      o_set <= i_req;
    end
  end
endmodule : irq_event_source

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
  import irq_flag_pkg::*;
;
  logic             clk;
  logic             srst;
  logic [3:0]       addr;
  logic [15:0]      wdata;
  logic             wr;
  logic             rd;
  logic [15:0]      rdata;
  logic [34:0]      req;
  logic [34:0]      ev;
  logic [3:0][15:0] fl;
  logic [3:0][15:0] model;
  logic [15:0]      rd_exp;
  int               miscompares;
  int               checked;
  int               seed;

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  irq_event_source src_u (.i_sys_clk(clk), .i_srst(srst), .i_req(req), .o_set(ev));

  // Event ports follow word order, highest bit first, which the reference mapping relies on.
  irq_flag_bank dut_u (
    .i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_adc_done_flag_set(ev[0]), .i_uart_a_tx_flag_set(ev[1]), .i_uart_a_rx_flag_set(ev[2]),
    .i_spi_a_event_flag_set(ev[3]), .i_spi_a_fault_flag_set(ev[4]), .i_timer_c_flag_set(ev[5]),
    .i_timer_b_flag_set(ev[6]), .i_compare_b_flag_set(ev[7]), .i_capture_b_flag_set(ev[8]),
    .i_timer_a_flag_set(ev[9]), .i_compare_a_flag_set(ev[10]), .i_capture_a_flag_set(ev[11]),
    .i_ext_irq_a_flag_set(ev[12]), .i_uart_b_tx_flag_set(ev[13]), .i_uart_b_rx_flag_set(ev[14]),
    .i_ext_irq_c_flag_set(ev[15]), .i_timer_e_flag_set(ev[16]), .i_timer_d_flag_set(ev[17]),
    .i_compare_d_flag_set(ev[18]), .i_compare_c_flag_set(ev[19]), .i_ext_irq_b_flag_set(ev[20]),
    .i_pin_change_flag_set(ev[21]), .i_comparator_flag_set(ev[22]), .i_i2c_a_master_flag_set(ev[23]),
    .i_i2c_a_slave_flag_set(ev[24]), .i_parallel_port_flag_set(ev[25]), .i_compare_e_flag_set(ev[26]),
    .i_capture_e_flag_set(ev[27]), .i_capture_d_flag_set(ev[28]), .i_capture_c_flag_set(ev[29]),
    .i_spi_b_event_flag_set(ev[30]), .i_spi_b_fault_flag_set(ev[31]), .i_calendar_flag_set(ev[32]),
    .i_i2c_b_master_flag_set(ev[33]), .i_i2c_b_slave_flag_set(ev[34]),
    .o_irq_flags_0(fl[0]), .o_irq_flags_1(fl[1]), .o_irq_flags_2(fl[2]), .o_irq_flags_3(fl[3])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Scatter the event vector onto the implemented bits of word w.
  function automatic logic [15:0] ev_word(input logic [34:0] e, input int w);
    int          k;
    logic [15:0] r;
    k = 0;
    r = 16'h0;
    for (int i = 0; i < 4; i++) begin
      for (int b = 15; b >= 0; b--) begin
        if (IMPL_MASKS[i][b]) begin
          if (i == w) r[b] = e[k];
          k++;
        end
      end
    end
    return r;
  endfunction : ev_word

  // Sparse random events, so flags are not simply all set after a few cycles.
  function automatic logic [34:0] sparse();
    return 35'({$random(seed), $random(seed)} & {$random(seed), $random(seed)} & {$random(seed), $random(seed)});
  endfunction : sparse

  // reference flag words
  // Events set bits, a write replaces the word, and an event beats a clearing write.
  always @(posedge clk) begin
    rd_exp <= (rd && !srst && addr < 4'h4) ? model[addr[1:0]] : 16'h0;
    for (int w = 0; w < 4; w++) begin
      if (srst) model[w] <= 16'h0;
      else if (wr && addr == w) model[w] <= (wdata | ev_word(ev, w)) & IMPL_MASKS[w];
      else model[w] <= model[w] | ev_word(ev, w);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // One bus cycle plus the event request for the next cycle, all launched after the edge.
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d, input logic [34:0] e);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    req <= e;
  endtask : bus

  task automatic read_all();
    for (int a = 0; a < 16; a++) begin
      bus(1'b0, 1'b1, 4'(a), 16'h0, 35'h0);
    end
    bus(1'b0, 1'b0, 4'h0, 16'h0, 35'h0);
  endtask : read_all

  // Settled outputs are compared mid-cycle against the reference, every cycle out of reset.
  always @(negedge clk) begin
    if (srst === 1'b0) begin
      for (int w = 0; w < 4; w++) begin
        check(fl[w], model[w]); // flag words
      end
      check(rdata, rd_exp); // read port
    end
  end

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int op;
    seed = 59;
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0;
    req = 35'h0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Reset values and unmapped addresses.
    read_all();
    // Each source alone, then cleared by software.
    for (int k = 0; k < 35; k++) begin
      bus(1'b0, 1'b0, 4'h0, 16'h0, 35'(1) << k);
      bus(1'b0, 1'b0, 4'h0, 16'h0, 35'h0);
      for (int a = 0; a < 4; a++) begin
        bus(1'b1, 1'b0, 4'(a), 16'h0, 35'h0);
      end
    end
    // All ones to every address, unused bits and unmapped words must stay clear.
    for (int a = 0; a < 16; a++) begin
      bus(1'b1, 1'b0, 4'(a), 16'hffff, 35'h0);
    end
    read_all();
    // Events landing on the same edge as clearing writes.
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, 1'b0, 4'h0, 16'h0, '1);
      bus(1'b1, 1'b0, 4'(a), 16'h0, 35'h0);
      bus(1'b0, 1'b1, 4'(a), 16'h0, 35'h0);
    end
    // Random traffic with back-to-back accesses.
    repeat (3000) begin
      op = $random(seed);
      bus(op[1:0] == 2'h1, op[1:0] == 2'h2, op[7:4], 16'($random(seed)), sparse());
    end
    // Reset in mid-run with flags set; the extra idle cycle lets the events land before reset.
    bus(1'b0, 1'b0, 4'h0, 16'h0, '1);
    bus(1'b0, 1'b0, 4'h0, 16'h0, 35'h0);
    bus(1'b0, 1'b0, 4'h0, 16'h0, 35'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    read_all();
    // Let the last read data stand past a compare before the run ends.
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : tb
